//--- tb/byte_crc16_generator_test.sv
// Self-checking bench for the byte CRC generator register block
`timescale 1ns/10ps
`include "bcrc_map.svh"

module byte_crc16_generator_test;
    logic        core_clk, rst, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] sum;
    int          n_errors, n_checks, i, j;

    bcrc_top #(.ADDR_W(4)) uut
    (
        .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    // ----------------------------------------
    // Bus tasks and reference
    // ----------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] s, input logic [7:0] b,
                                             input logic sel);
        logic [15:0] t;
        t = s ^ {b, 8'h00};
        repeat (8)
            t = t[15] ? ((t << 1) ^ (sel ? 16'h8005 : 16'h1021)) : (t << 1);
        return t;
    endfunction : crc_step

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done)
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                done = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        logic done;
        logic [33:0] got;
        done = 1'b0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done)
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                got = {s_axi_rresp, s_axi_rdata};
                done = 1'b1;
            end
        end
        s_axi_rready <= 1'b0;
        chk(got, {`BCRC_RESP_OKAY, 24'h00_0000, e});
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        axi_write(a, d, 4'h1, resp);
        chk({32'h0000_0000, resp}, {32'h0000_0000, `BCRC_RESP_OKAY});
    endtask : wr

    task automatic sum_chk(input logic [15:0] e);
        rd(`BCRC_OFS_SUM_HIGH, e[15:8]);
        rd(`BCRC_OFS_SUM_LOW, e[7:0]);
    endtask : sum_chk

    task automatic feed(input logic [7:0] b, input logic sel);
        sum = crc_step(sum, b, sel);
        wr(`BCRC_OFS_BYTE_IN, {24'h00_0000, b});
    endtask : feed

    task automatic clear_sum();
        wr(`BCRC_OFS_SUM_LOW, 32'h0000_0000);
        wr(`BCRC_OFS_SUM_HIGH, 32'h0000_0000);
        sum = 16'h0000;
    endtask : clear_sum

    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        {rst, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b11000;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 14'h0000;
        s_axi_wdata = 32'h0000_0000;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(`BCRC_OFS_POLYNOMIAL_SELECT_CTRL, 8'h00);
        rd(`BCRC_OFS_BYTE_IN, 8'h00);
        sum_chk(16'h0000);
        wr(`BCRC_OFS_POLYNOMIAL_SELECT_CTRL, 32'hffff_ffff);
        rd(`BCRC_OFS_POLYNOMIAL_SELECT_CTRL, 8'h01);
        for (i = 0; i < 2; i++)
        begin
            wr(`BCRC_OFS_POLYNOMIAL_SELECT_CTRL, 32'(i));
            for (j = 0; j < 8; j++)
            begin
                clear_sum();
                feed(j[7:0], i[0]);
                sum_chk(sum);
            end
            chk({18'h0_0000, sum}, {18'h0_0000, i[0] ? 16'h8011 : 16'h70e7});
            clear_sum();
            for (j = 0; j < 4; j++)
            begin
                feed(8'(32'h1234_5678 >> (8 * j)), i[0]);
                sum_chk(sum);
            end
            chk({18'h0_0000, sum}, {18'h0_0000, i[0] ? 16'h5c43 : 16'hd0fa});
        end
        // Seeded start exercises direct checksum loads
        wr(`BCRC_OFS_POLYNOMIAL_SELECT_CTRL, 32'h0000_0000);
        wr(`BCRC_OFS_SUM_LOW, 32'h0000_0034);
        wr(`BCRC_OFS_SUM_HIGH, 32'h0000_0012);
        sum = 16'h1234;
        feed(8'hab, 1'b0);
        sum_chk(sum);
        rd(`BCRC_OFS_BYTE_IN, 8'hab);
        sum_chk(sum);
        axi_write(`BCRC_OFS_BYTE_IN, 32'h0000_0055, 4'h0, resp);
        chk({32'h0000_0000, resp}, {32'h0000_0000, `BCRC_RESP_OKAY});
        sum_chk(sum);
        rd(`BCRC_OFS_BYTE_IN, 8'hab);
        axi_write(4'h2, 32'h0000_00ff, 4'hf, resp);
        chk({32'h0000_0000, resp}, {32'h0000_0000, `BCRC_RESP_SLVERR});
        sum_chk(sum);
        rd(`BCRC_OFS_POLYNOMIAL_SELECT_CTRL, 8'h00);
        // Clock enable low freezes the checksum
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (4) @(posedge core_clk);
        clk_en <= 1'b1;
        sum_chk(sum);
        complete_run();
    end
endmodule : byte_crc16_generator_test

//--- verilog/bcrc_byte_step.sv
// Combinational one-byte CRC update, MSB first
`timescale 1ns/10ps
`include "bcrc_map.svh"

module bcrc_byte_step
(
    input  wire bcrc_pkg::bcrc_step_t step_in,
    output logic [15:0]               sum_out
);

    wire [15:0] polynomial_select = step_in.crc16 ? `BCRC_POLYNOMIAL_SELECT_CRC16 : `BCRC_POLYNOMIAL_SELECT_CCITT; // RULE9 RULE4

    // ------------------------------------------------------------
    // Bit-serial loop unrolled over the byte
    // ------------------------------------------------------------
    always_comb
    begin
        logic [15:0] tmp;
        logic        top;
        top = 1'b0;
        tmp = step_in.sum ^ {step_in.data, 8'h00}; // RULE7
        for (int i = 0; i < 8; i++) // RULE10
        begin
            top = tmp[15];
            tmp = {tmp[14:0], 1'b0}; // RULE8
            if (top)
            begin
                tmp = tmp ^ polynomial_select; // RULE8
            end
        end
        sum_out = tmp; // RULE5
    end

endmodule : bcrc_byte_step

//--- verilog/bcrc_map.svh
// Register map, field positions, reset values and constants of the byte CRC generator
`ifndef BCRC_MAP_SVH
`define BCRC_MAP_SVH

`define BCRC_OFS_POLYNOMIAL_SELECT_CTRL  4'h0
`define BCRC_OFS_BYTE_IN    4'h4
`define BCRC_OFS_SUM_LOW    4'h8
`define BCRC_OFS_SUM_HIGH   4'hc
`define BCRC_POLYNOMIAL_SELECT_SEL_BIT   0
`define BCRC_RST_BYTE       8'h00
`define BCRC_POLYNOMIAL_SELECT_CCITT     16'h1021
`define BCRC_POLYNOMIAL_SELECT_CRC16     16'h8005
`define BCRC_RESP_OKAY      2'b00
`define BCRC_RESP_SLVERR    2'b10

`endif

//--- verilog/bcrc_pkg.sv
// Types shared by the byte CRC generator
package bcrc_pkg;

    typedef struct packed {
        logic [7:0]  data;
        logic [15:0] sum;
        logic        crc16;
    } bcrc_step_t;

    typedef enum logic [2:0] {
        BCRC_RD_IDLE = 3'b001,
        BCRC_RD_RESP = 3'b010,
        BCRC_RD_HOLD = 3'b100
    } bcrc_rd_state_t;

endpackage : bcrc_pkg

//--- verilog/bcrc_top.sv
// AXI4-Lite register block of the byte-wide CRC-16 generator
// Overview of operation
// RULE1 - Input byte write folds into checksum
// RULE2 - Update starts from held checksum pair
// RULE3 - Control bit 0 picks CCITT or CRC-16
// RULE4 - Only those two polynomials exist
// RULE5 - Whole byte per write, 16-bit result
// RULE6 - New checksum ready one cycle later
// RULE7 - Input byte XORed into checksum high
// RULE8 - Shift left, XOR polynomial if MSB set
// RULE9 - Constant 8005 or 1021 by selection
// RULE10 - Eight steps; result becomes new checksum
// RULE11 - Software clears checksum before new run
// RULE12 - Checksum low/high bytes read and write
// RULE13 - Control bits 7..1 read zero
// RULE14 - Checksum byte writes load directly
// RULE15 - Input readback; reads never update
`timescale 1ns/10ps
`include "bcrc_map.svh"

module bcrc_top
#(
    parameter int ADDR_W = 4
)
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic              polynomial_select_ff;
    logic [7:0]        crc_byte_input_ff;
    logic [15:0]       running_checksum_ff;
    logic              aw_held_ff;
    logic              w_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic [31:0]       w_data_ff;
    logic              w_strb0_ff;
    logic              awready_ff;
    logic              wready_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              arready_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;

    // ------------------------------------------------------------
    // Write channel capture, either order
    // ------------------------------------------------------------
    wire aw_fire = s_axi_awvalid && awready_ff;
    wire w_fire  = s_axi_wvalid && wready_ff;

    wire              aw_have = aw_held_ff || aw_fire;
    wire              w_have  = w_held_ff || w_fire;
    wire [ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    wire [31:0]       wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
    wire              wr_lane = w_held_ff ? w_strb0_ff : s_axi_wstrb[0];
    wire              wr_go   = aw_have && w_have && !bvalid_ff;
    wire [7:0]        wr_byte = wr_data[7:0];

    // Only byte lane 0 carries register bits
    wire wr_polynomial_select = wr_go && wr_lane && (wr_addr == `BCRC_OFS_POLYNOMIAL_SELECT_CTRL);
    wire wr_in   = wr_go && wr_lane && (wr_addr == `BCRC_OFS_BYTE_IN);
    wire wr_lo   = wr_go && wr_lane && (wr_addr == `BCRC_OFS_SUM_LOW);
    wire wr_hi   = wr_go && wr_lane && (wr_addr == `BCRC_OFS_SUM_HIGH);
    wire wr_map  = (wr_addr == `BCRC_OFS_POLYNOMIAL_SELECT_CTRL) || (wr_addr == `BCRC_OFS_BYTE_IN)
                || (wr_addr == `BCRC_OFS_SUM_LOW) || (wr_addr == `BCRC_OFS_SUM_HIGH);

    // ------------------------------------------------------------
    // CRC datapath
    // ------------------------------------------------------------
    bcrc_pkg::bcrc_step_t step;
    logic [15:0]          step_sum;

    assign step.data  = wr_byte;
    assign step.sum   = running_checksum_ff; // RULE2
    assign step.crc16 = polynomial_select_ff; // RULE3

    bcrc_byte_step u_step
    (
        .step_in (step),
        .sum_out (step_sum)
    );

    wire [15:0] nxt_sum = wr_in ? step_sum // RULE1 RULE6
                        : wr_hi ? {wr_byte, running_checksum_ff[7:0]} // RULE14 RULE12
                        : wr_lo ? {running_checksum_ff[15:8], wr_byte} // RULE14 RULE12
                        : running_checksum_ff;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    wire ar_fire = s_axi_arvalid && arready_ff;

    wire [31:0] rd_mux =
        (s_axi_araddr == `BCRC_OFS_POLYNOMIAL_SELECT_CTRL) ? {31'h0, polynomial_select_ff} // RULE13
      : (s_axi_araddr == `BCRC_OFS_BYTE_IN)   ? {24'h00_0000, crc_byte_input_ff} // RULE15
      : (s_axi_araddr == `BCRC_OFS_SUM_LOW)   ? {24'h00_0000, running_checksum_ff[7:0]}
      : (s_axi_araddr == `BCRC_OFS_SUM_HIGH)  ? {24'h00_0000, running_checksum_ff[15:8]}
      : 32'h0000_0000;
    wire rd_map = (s_axi_araddr == `BCRC_OFS_POLYNOMIAL_SELECT_CTRL) || (s_axi_araddr == `BCRC_OFS_BYTE_IN)
               || (s_axi_araddr == `BCRC_OFS_SUM_LOW) || (s_axi_araddr == `BCRC_OFS_SUM_HIGH);

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            polynomial_select_ff <= 1'b0;
            crc_byte_input_ff    <= `BCRC_RST_BYTE;
            running_checksum_ff  <= {`BCRC_RST_BYTE, `BCRC_RST_BYTE};
        end
        else if (clk_en)
        begin
            if (wr_polynomial_select)
                polynomial_select_ff <= wr_byte[`BCRC_POLYNOMIAL_SELECT_SEL_BIT]; // RULE3
            if (wr_in)
                crc_byte_input_ff <= wr_byte; // RULE15
            running_checksum_ff <= nxt_sum; // RULE1
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= 32'h0000_0000;
            w_strb0_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `BCRC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            aw_held_ff <= aw_have && !wr_go;
            w_held_ff  <= w_have && !wr_go;
            if (aw_fire)
                aw_addr_ff <= s_axi_awaddr;
            if (w_fire)
            begin
                w_data_ff  <= s_axi_wdata;
                w_strb0_ff <= s_axi_wstrb[0];
            end
            awready_ff <= !aw_have && !bvalid_ff && !wr_go;
            wready_ff  <= !w_have && !bvalid_ff && !wr_go;
            if (wr_go)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_map ? `BCRC_RESP_OKAY : `BCRC_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `BCRC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            arready_ff <= !ar_fire && !rvalid_ff;
            if (ar_fire)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rd_mux;
                rresp_ff  <= rd_map ? `BCRC_RESP_OKAY : `BCRC_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rvalid_ff  <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sum_updates_next: assert property (@(posedge core_clk) disable iff (rst) // RULE6
        (clk_en && wr_in) |=> running_checksum_ff == $past(step_sum))
        else $error("checksum not updated one cycle after input write");

    a_ccitt_one_byte: assert property (@(posedge core_clk) disable iff (rst) // RULE9
        (clk_en && wr_in && !polynomial_select_ff && running_checksum_ff == 16'h0000
         && wr_byte == 8'h01) |=> running_checksum_ff == 16'h1021)
        else $error("CCITT result for byte 01 wrong");

    a_crc16_one_byte: assert property (@(posedge core_clk) disable iff (rst) // RULE9
        (clk_en && wr_in && polynomial_select_ff && running_checksum_ff == 16'h0000
         && wr_byte == 8'h03) |=> running_checksum_ff == 16'h000a)
        else $error("CRC-16 result for byte 03 wrong");

    a_sum_hold_idle: assert property (@(posedge core_clk) disable iff (rst) // RULE15
        (!(wr_in || wr_lo || wr_hi)) |=> $stable(running_checksum_ff))
        else $error("checksum changed without a write");

    a_low_load: assert property (@(posedge core_clk) disable iff (rst) // RULE14
        (clk_en && wr_lo) |=> running_checksum_ff[7:0] == $past(wr_byte))
        else $error("checksum low write not loaded");

    a_high_load: assert property (@(posedge core_clk) disable iff (rst) // RULE12
        (clk_en && wr_hi) |=> running_checksum_ff[15:8] == $past(wr_byte))
        else $error("checksum high write not loaded");

    a_ctrl_upper_zero: assert property (@(posedge core_clk) disable iff (rst) // RULE13
        (clk_en && ar_fire && s_axi_araddr == `BCRC_OFS_POLYNOMIAL_SELECT_CTRL)
        |=> rvalid_ff && rdata_ff[31:1] == 31'h0)
        else $error("control upper bits not zero");

    a_input_readback: assert property (@(posedge core_clk) disable iff (rst) // RULE15
        (clk_en && ar_fire && s_axi_araddr == `BCRC_OFS_BYTE_IN)
        |=> rdata_ff[7:0] == $past(crc_byte_input_ff))
        else $error("input readback mismatch");

    a_polynomial_select_store: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        (clk_en && wr_polynomial_select) |=> polynomial_select_ff == $past(wr_byte[`BCRC_POLYNOMIAL_SELECT_SEL_BIT]))
        else $error("polynomial select not stored");

    a_rd_answer_next: assert property (@(posedge core_clk) disable iff (rst) // RULE15
        (clk_en && ar_fire) |=> rvalid_ff)
        else $error("read answer not one cycle after address");

    a_wr_answer_ok: assert property (@(posedge core_clk) disable iff (rst) // RULE12
        (clk_en && wr_go && wr_map) |=> bvalid_ff && bresp_ff == `BCRC_RESP_OKAY)
        else $error("mapped write not answered okay");

    a_unmapped_err: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        (clk_en && wr_go && !wr_map) |=> bvalid_ff && bresp_ff == `BCRC_RESP_SLVERR)
        else $error("unmapped write not answered with error");

    // One transfer per direction in flight
    a_read_blocks_ar: assert property (@(posedge core_clk) disable iff (rst) // RULE15
        rvalid_ff |-> !arready_ff)
        else $error("read address accepted while answer pending");

    a_resp_blocks_aw: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        bvalid_ff |-> !awready_ff && !wready_ff)
        else $error("write accepted while response pending");

    a_freeze_state: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        !clk_en |=> $stable(running_checksum_ff) && $stable(polynomial_select_ff)
                    && $stable(crc_byte_input_ff))
        else $error("state moved while clock enable low");

    a_input_capture: assert property (@(posedge core_clk) disable iff (rst) // RULE15
        (clk_en && wr_in) |=> crc_byte_input_ff == $past(wr_byte))
        else $error("input byte not captured");

    a_crc16_byte_one: assert property (@(posedge core_clk) disable iff (rst) // RULE9
        (clk_en && wr_in && polynomial_select_ff && running_checksum_ff == 16'h0000
         && wr_byte == 8'h01) |=> running_checksum_ff == 16'h8005)
        else $error("CRC-16 result for byte 01 wrong");

    a_ccitt_byte_seven: assert property (@(posedge core_clk) disable iff (rst) // RULE10
        (clk_en && wr_in && !polynomial_select_ff && running_checksum_ff == 16'h0000
         && wr_byte == 8'h07) |=> running_checksum_ff == 16'h70e7)
        else $error("CCITT result for byte 07 wrong");

    // Lane 0 off means the write is answered but changes nothing
    a_strobe_off: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        (clk_en && wr_go && !wr_lane) |=> $stable(running_checksum_ff))
        else $error("checksum changed by write without lane 0");

    a_low_keeps_high: assert property (@(posedge core_clk) disable iff (rst) // RULE14
        (clk_en && wr_lo) |=> $stable(running_checksum_ff[15:8]))
        else $error("checksum low write disturbed high byte");

endmodule : bcrc_top
